// [pkg/serdes_params.svh]
// Purpose: constants shared by the serdes pin control design
// Assumes: included by package and modules by bare name
// Notes:   offsets are Avalon byte addresses, one word each
`ifndef SERDES_PARAMS_SVH
`define SERDES_PARAMS_SVH

// ==========================================================
// frame and word geometry
`define WORD_W      10
`define FRAME_W     12
`define FRAME_LAST  4'hB
`define HALF_FRAME  4'h6

// ==========================================================
// training and lock timing, in word frames; REF_STALE in system clocks
`define SYNC_WORD   10'h3E0
`define TRAIN_MIN   11'h400
`define LOSS_LIMIT  2'h3
`define REF_STALE   6'h3F

// ==========================================================
// register map
`define OFS_CTRL    4'h0
`define OFS_STATUS  4'h4
`define OFS_RX_WORD 4'h8
`define OFS_TX_HOLD 4'hC
`define CTRL_RESET  8'h00

// control field positions
`define CB_TX_EDGE  0
`define CB_SER_OE   1
`define CB_TX_WAKE  2
`define CB_TRAIN_A  3
`define CB_TRAIN_B  4
`define CB_RX_EDGE  5
`define CB_RX_OE    6
`define CB_RX_WAKE  7

`endif

// [pkg/serdes_pkg.sv]
// Purpose: types and frame helpers for the serdes pin control
// Assumes: serdes_params.svh on the include path
// Notes:   frame = start 1, data lsb first, stop 0
`default_nettype none
`include "serdes_params.svh"

package serdes_pkg;

   // ==========================================================
   // receive lock states
   typedef enum logic [1:0] {RX_HUNT, RX_CHECK, RX_LOCKED} lock_fsm_t;

   typedef struct packed {
      logic                 wclk;
      logic [`WORD_W-1:0]   hold;
      logic [`FRAME_W-1:0]  sh;
      logic [3:0]           pos;
      logic [10:0]          cnt;
      logic                 busy;
   } tx_state_t;

   typedef struct packed {
      logic [`FRAME_W-1:0]  sh;
      logic [3:0]           pos;
      lock_fsm_t            st;
      logic [1:0]           bad;
      logic                 ref_lvl;
      logic [5:0]           age;
      logic [`WORD_W-1:0]   fresh;
      logic [`WORD_W-1:0]   word;
      logic                 rclk;
      logic                 lock_n;
   } rx_state_t;

   typedef struct packed {
      logic [7:0]           ctrl;
      logic                 wr;
      logic [31:0]          rdata;
      logic                 ser_p;
      logic                 ser_n;
      logic                 ser_oe_n;
      logic [`WORD_W-1:0]   pw;
      logic                 pw_oe_n;
      logic                 rck;
      logic                 rck_oe_n;
      logic                 lck;
      logic                 lck_oe_n;
      logic [2:0]           tap;
   } top_state_t;

   // ==========================================================
   // frame helpers
   function automatic logic [`FRAME_W-1:0] frame_pack(input logic [`WORD_W-1:0] w);
      logic [`FRAME_W-1:0] f;
      f = '0;
      f[`FRAME_W-1] = 1'b1;
      for (int i = 0; i < `WORD_W; i++) begin
         f[`WORD_W-i] = w[i];
      end
      return f;
   endfunction : frame_pack

   function automatic logic [`WORD_W-1:0] frame_data(input logic [`FRAME_W-1:0] f);
      logic [`WORD_W-1:0] w;
      w = '0;
      for (int i = 0; i < `WORD_W; i++) begin
         w[i] = f[`WORD_W-i];
      end
      return w;
   endfunction : frame_data

   function automatic logic frame_ok(input logic [`FRAME_W-1:0] f);
      return f[`FRAME_W-1] & ~f[0];
   endfunction : frame_ok

endpackage : serdes_pkg
`default_nettype wire

// [hdl/ser_frame_tx.sv]
// Purpose: serializer word capture, framing and training
// Assumes: one serial bit per system clock
// Notes:   word clock is sampled, so it must be slow
`default_nettype none
`include "serdes_params.svh"

module ser_frame_tx import serdes_pkg::*; (
   // clock and reset
   input  wire logic               sys_clk_i,
   input  wire logic               resetn_i,
   input  wire logic               ce_i,
   // control
   input  wire logic               awake_i,
   input  wire logic               edge_rise_i,
   input  wire logic               train_a_i,
   input  wire logic               train_b_i,
   // parallel side
   input  wire logic               word_clk_i,
   input  wire logic [`WORD_W-1:0] word_i,
   // results
   output logic                    ser_bit_o,
   output logic                    busy_o,
   output logic [`WORD_W-1:0]      hold_o
);

   tx_state_t s_q;
   tx_state_t s_d;
   logic      req;
   logic      strobe;

   // ==========================================================
   // next state
   always_comb begin
      s_d    = s_q;
      req    = train_a_i | train_b_i;
      strobe = edge_rise_i ? (word_clk_i & ~s_q.wclk)
                           : (~word_clk_i & s_q.wclk);
      s_d.wclk = word_clk_i;
      if (!awake_i) begin
         // sleep: framing stops, training forgotten
         s_d.pos  = 4'h0;
         s_d.cnt  = 11'h000;
         s_d.sh   = '0;
         s_d.busy = 1'b0;
      end else begin
         if (strobe) begin
            s_d.hold = word_i;
         end
         if (s_q.pos == `FRAME_LAST) begin
            s_d.pos = 4'h0;
            if (req) begin
               s_d.sh   = frame_pack(`SYNC_WORD);
               s_d.cnt  = `TRAIN_MIN - 11'h001;
               s_d.busy = 1'b1;
            end else if (s_q.cnt != 11'h000) begin
               s_d.sh   = frame_pack(`SYNC_WORD);
               s_d.cnt  = s_q.cnt - 11'h001;
               s_d.busy = 1'b1;
            end else begin
               s_d.sh   = frame_pack(s_q.hold);
               s_d.busy = 1'b0;
            end
         end else begin
            s_d.pos = s_q.pos + 4'h1;
            s_d.sh  = {s_q.sh[`FRAME_W-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign ser_bit_o = s_q.sh[`FRAME_W-1];
   assign busy_o    = s_q.busy;
   assign hold_o    = s_q.hold;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   a_rise_capture: assert property (ce_i && awake_i && edge_rise_i && word_clk_i && !s_q.wclk
      |=> s_q.hold == $past(word_i)) else $error("word not captured on rising edge");
   a_fall_ignore: assert property (ce_i && awake_i && !edge_rise_i && word_clk_i
      |=> s_q.hold == $past(s_q.hold)) else $error("word captured on wrong edge");
   a_train_sync: assert property (ce_i && awake_i && s_q.pos == `FRAME_LAST && req
      |=> s_q.sh == frame_pack(`SYNC_WORD) && s_q.cnt == 11'h3FF)
      else $error("training request did not start sync frames");
   a_frame_marks: assert property (ce_i && awake_i && s_q.pos == `FRAME_LAST
      |=> s_q.sh[`FRAME_W-1] && !s_q.sh[0]) else $error("frame lacks clock bits");

endmodule : ser_frame_tx
`default_nettype wire

// [hdl/des_frame_rx.sv]
// Purpose: deserializer framing, lock detect, recovered clock
// Assumes: one serial bit per system clock
// Notes:   reference clock activity gates acquisition
`default_nettype none
`include "serdes_params.svh"

module des_frame_rx import serdes_pkg::*; (
   // clock and reset
   input  wire logic               sys_clk_i,
   input  wire logic               resetn_i,
   input  wire logic               ce_i,
   // control
   input  wire logic               awake_i,
   input  wire logic               edge_rise_i,
   // link
   input  wire logic               ser_in_p_i,
   input  wire logic               ser_in_n_i,
   input  wire logic               ref_clk_i,
   // results
   output logic                    lock_n_o,
   output logic                    rclk_o,
   output logic [`WORD_W-1:0]      word_o
);

   rx_state_t s_q;
   rx_state_t s_d;
   logic      good;
   logic      ref_ok;
   logic      bound;

   // ==========================================================
   // next state
   always_comb begin
      s_d       = s_q;
      s_d.sh    = {s_q.sh[`FRAME_W-2:0], ser_in_p_i & ~ser_in_n_i};
      good      = frame_ok(s_d.sh);
      bound     = (s_q.pos == `FRAME_LAST);
      ref_ok    = (s_q.age != `REF_STALE);
      s_d.pos   = bound ? 4'h0 : s_q.pos + 4'h1;
      // reference activity: age resets on every level change
      s_d.ref_lvl = ref_clk_i;
      if (ref_clk_i != s_q.ref_lvl) begin
         s_d.age = 6'h00;
      end else if (ref_ok) begin
         s_d.age = s_q.age + 6'h01;
      end
      case (s_q.st)
         RX_HUNT: begin
            if (good && ref_ok) begin
               s_d.st  = RX_CHECK;
               s_d.pos = 4'h0;
            end
         end
         RX_CHECK: begin
            if (bound) begin
               s_d.st     = (good && ref_ok) ? RX_LOCKED : RX_HUNT;
               s_d.lock_n = ~(good && ref_ok);
               s_d.fresh  = frame_data(s_d.sh);
               // misses left from an earlier lock must not count again
               s_d.bad    = 2'h0;
            end
         end
         RX_LOCKED: begin
            if (!ref_ok) begin
               s_d.st     = RX_HUNT;
               s_d.lock_n = 1'b1;
            end else if (bound) begin
               if (good) begin
                  s_d.bad   = 2'h0;
                  s_d.fresh = frame_data(s_d.sh);
               end else if (s_q.bad == `LOSS_LIMIT) begin
                  s_d.st     = RX_HUNT;
                  s_d.lock_n = 1'b1;
                  s_d.bad    = 2'h0;
               end else begin
                  s_d.bad = s_q.bad + 2'h1;
               end
            end
         end
         default: s_d.st = RX_HUNT;
      endcase
      // word-rate clock, high in the first half of the frame
      s_d.rclk = (s_d.pos < `HALF_FRAME);
      if (edge_rise_i ? (s_d.pos == `HALF_FRAME) : (s_d.pos == 4'h0)) begin
         s_d.word = s_q.fresh;
      end
      if (!awake_i) begin
         s_d        = '0;
         s_d.lock_n = 1'b1;
         s_d.st     = RX_HUNT;
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q        <= '0;
         s_q.lock_n <= 1'b1;
         s_q.st     <= RX_HUNT;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign lock_n_o = s_q.lock_n;
   assign rclk_o   = s_q.rclk;
   assign word_o   = s_q.word;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   a_loss_fourth: assert property (ce_i && awake_i && s_q.st == RX_LOCKED && bound
      && s_q.bad == 2'h3 && !good |=> s_q.lock_n && s_q.st == RX_HUNT)
      else $error("lock kept after four bad frames");
   a_lock_hold: assert property (ce_i && awake_i && s_q.st == RX_LOCKED && s_q.bad < 2'h3
      && ref_ok |=> !s_q.lock_n) else $error("lock lost too early");
   a_lock_entry: assert property ($fell(s_q.lock_n) |-> $past(s_q.st) == RX_CHECK)
      else $error("lock gained without a second good frame");

endmodule : des_frame_rx
`default_nettype wire

// [hdl/serdes_pin_ctl.sv]
// Purpose: pin control of a 10-bit serializer and deserializer
// Assumes: all pins synchronous to sys_clk_i, one bit a cycle
// Notes:   control bits live in an Avalon-MM register file
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`default_nettype none
`include "serdes_params.svh"

// ==========================================================
// top level
// Functional notes
// - capture the ten input data lines on the chosen word clock edge
// - edge select high strobes on rising edge, low on falling edge
// - serial output enable low floats both serial outputs
// - serializer sleep stops framing and floats its outputs
// - a training request sends at least 1024 sync frames, more while held
// - the two training request inputs are ORed together
// - lock flag low once locked, high while not locked
// - recovered clock runs at the word rate from the embedded clock
// - receive edge select chooses which recovered clock edge data meets
// - awake with output enable low floats data and clock, lock driven
// - receiver sleep floats data, lock and clock whatever the enable
// - while the lock flag is high data and clock stay floating
// - awake, enabled and locked drives data and running clock
// - active lock flag follows the current lock state
// - undriven test data, mode and reset inputs read as high
// - two embedded clock bits frame each word, always one transition
// - loss of lock after four bad frames in a row, or at once when the reference goes stale
module serdes_pin_ctl import serdes_pkg::*; (
   // clock, reset and enable
   input  wire logic               sys_clk_i,
   input  wire logic               resetn_i,
   input  wire logic               ce_i,
   // avalon-mm register slave
   input  wire logic [3:0]         avs_address_i,
   input  wire logic               avs_read_i,
   input  wire logic               avs_write_i,
   input  wire logic [3:0]         avs_byteenable_i,
   input  wire logic [31:0]        avs_writedata_i,
   output logic [31:0]             avs_readdata_o,
   output logic                    avs_waitrequest_o,
   // serializer parallel side
   input  wire logic               tx_word_clk_i,
   input  wire logic [`WORD_W-1:0] tx_word_i,
   // serializer serial side
   output logic                    ser_out_p_o,
   output logic                    ser_out_n_o,
   output logic                    ser_out_oe_n_o,
   // deserializer serial side
   input  wire logic               ser_in_p_i,
   input  wire logic               ser_in_n_i,
   input  wire logic               rx_reference_clk_i,
   // deserializer parallel side
   output logic [`WORD_W-1:0]      par_word_out_o,
   output logic                    par_word_out_oe_n_o,
   output logic                    rec_clk_o,
   output logic                    rec_clk_oe_n_o,
   output logic                    lock_n_o,
   output logic                    lock_oe_n_o,
   // test access inputs with pull-up behaviour
   input  wire logic [2:0]         tap_drive_i,
   input  wire logic [2:0]         tap_level_i
);

   top_state_t         s_q;
   top_state_t         s_d;
   logic               tx_bit;
   logic               tx_busy;
   logic [`WORD_W-1:0] tx_hold;
   logic               rx_lock_n;
   logic               rx_rclk;
   logic [`WORD_W-1:0] rx_word;
   logic               req;
   logic               tx_on;
   logic               rx_awake;
   logic               rx_drive;

   // ==========================================================
   // serializer
   // word clock is only sampled, so the host must keep it far
   // below half of sys_clk and one word per twelve cycles
   ser_frame_tx u_tx (
      .sys_clk_i   (sys_clk_i),
      .resetn_i    (resetn_i),
      .ce_i        (ce_i),
      .awake_i     (s_q.ctrl[`CB_TX_WAKE]),
      .edge_rise_i (s_q.ctrl[`CB_TX_EDGE]),
      .train_a_i   (s_q.ctrl[`CB_TRAIN_A]),
      .train_b_i   (s_q.ctrl[`CB_TRAIN_B]),
      .word_clk_i  (tx_word_clk_i),
      .word_i      (tx_word_i),
      .ser_bit_o   (tx_bit),
      .busy_o      (tx_busy),
      .hold_o      (tx_hold)
   );

   // ==========================================================
   // deserializer
   des_frame_rx u_rx (
      .sys_clk_i   (sys_clk_i),
      .resetn_i    (resetn_i),
      .ce_i        (ce_i),
      .awake_i     (s_q.ctrl[`CB_RX_WAKE]),
      .edge_rise_i (s_q.ctrl[`CB_RX_EDGE]),
      .ser_in_p_i  (ser_in_p_i),
      .ser_in_n_i  (ser_in_n_i),
      .ref_clk_i   (rx_reference_clk_i),
      .lock_n_o    (rx_lock_n),
      .rclk_o      (rx_rclk),
      .word_o      (rx_word)
   );

   // ==========================================================
   // next state: bus slave, pin drivers, enables
   always_comb begin
      s_d      = s_q;
      req      = avs_read_i | avs_write_i;
      tx_on    = s_q.ctrl[`CB_SER_OE] & s_q.ctrl[`CB_TX_WAKE];
      rx_awake = s_q.ctrl[`CB_RX_WAKE];
      rx_drive = rx_awake & s_q.ctrl[`CB_RX_OE] & ~rx_lock_n;

      // one wait state: answer prepared, then released
      if (req && s_q.wr) begin
         s_d.wr    = 1'b0;
         s_d.rdata = 32'h0000_0000;
         if (avs_address_i == `OFS_CTRL) begin
            s_d.rdata[7:0] = s_q.ctrl;
         end else if (avs_address_i == `OFS_STATUS) begin
            s_d.rdata[4:0] = {s_q.tap, tx_busy, rx_lock_n};
         end else if (avs_address_i == `OFS_RX_WORD) begin
            s_d.rdata[`WORD_W-1:0] = rx_word;
         end else if (avs_address_i == `OFS_TX_HOLD) begin
            s_d.rdata[`WORD_W-1:0] = tx_hold;
         end
      end else if (!s_q.wr) begin
         // master samples waitrequest low here: commit the write
         s_d.wr = 1'b1;
         if (avs_write_i && avs_address_i == `OFS_CTRL && avs_byteenable_i[0]) begin
            s_d.ctrl = avs_writedata_i[7:0];
         end
      end

      // serial output, differential pair
      s_d.ser_p    = tx_bit;
      s_d.ser_n    = ~tx_bit;
      s_d.ser_oe_n = ~tx_on;

      // lock flag floats only in receiver sleep
      s_d.lck      = rx_lock_n;
      s_d.lck_oe_n = ~rx_awake;

      // data and recovered clock need awake, enable and lock
      s_d.pw       = rx_word;
      s_d.rck      = rx_rclk;
      s_d.pw_oe_n  = ~rx_drive;
      s_d.rck_oe_n = ~rx_drive;

      // undriven test inputs pull high
      s_d.tap = tap_level_i | ~tap_drive_i;
   end

   // ==========================================================
   // state register, frozen while ce_i is low
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q          <= '0;
         s_q.ctrl     <= `CTRL_RESET;
         s_q.wr       <= 1'b1;
         s_q.ser_oe_n <= 1'b1;
         s_q.pw_oe_n  <= 1'b1;
         s_q.rck_oe_n <= 1'b1;
         s_q.lck      <= 1'b1;
         s_q.lck_oe_n <= 1'b1;
         s_q.tap      <= 3'h7;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs straight from the state register
   assign avs_readdata_o      = s_q.rdata;
   assign avs_waitrequest_o   = s_q.wr;
   assign ser_out_p_o         = s_q.ser_p;
   assign ser_out_n_o         = s_q.ser_n;
   assign ser_out_oe_n_o      = s_q.ser_oe_n;
   assign par_word_out_o      = s_q.pw;
   assign par_word_out_oe_n_o = s_q.pw_oe_n;
   assign rec_clk_o           = s_q.rck;
   assign rec_clk_oe_n_o      = s_q.rck_oe_n;
   assign lock_n_o            = s_q.lck;
   assign lock_oe_n_o         = s_q.lck_oe_n;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   a_ser_oe_float: assert property (ce_i && !s_q.ctrl[`CB_SER_OE]
      |=> ser_out_oe_n_o) else $error("serial out driven while disabled");

   a_tx_sleep_float: assert property (ce_i && !s_q.ctrl[`CB_TX_WAKE]
      |=> ser_out_oe_n_o) else $error("serial out driven in sleep");

   a_ser_pair: assert property (!ser_out_oe_n_o |-> ser_out_p_o != ser_out_n_o)
      else $error("serial pair not complementary");

   a_rx_sleep_all: assert property (ce_i && !rx_awake
      |=> lock_oe_n_o && par_word_out_oe_n_o && rec_clk_oe_n_o)
      else $error("receiver pin driven in sleep");

   a_oe_low_lock: assert property (ce_i && rx_awake && !s_q.ctrl[`CB_RX_OE]
      |=> !lock_oe_n_o && par_word_out_oe_n_o && rec_clk_oe_n_o)
      else $error("wrong pins floated with enable low");

   a_unlock_float: assert property (lock_n_o && !lock_oe_n_o
      |-> par_word_out_oe_n_o && rec_clk_oe_n_o)
      else $error("data driven while unlocked");

   a_drive_locked: assert property (ce_i && rx_drive
      |=> !par_word_out_oe_n_o && !rec_clk_oe_n_o)
      else $error("data not driven while locked");

   a_lock_track: assert property (ce_i && rx_awake
      |=> lock_n_o == $past(rx_lock_n))
      else $error("lock flag does not follow lock state");

   a_tap_pull: assert property (ce_i && !tap_drive_i[0] |=> s_q.tap[0])
      else $error("undriven test input not high");

   a_bus_answer: assert property (req && avs_waitrequest_o && ce_i
      |=> !avs_waitrequest_o) else $error("bus answer late");

endmodule : serdes_pin_ctl
`default_nettype wire

// [sim/link_peer.sv]
// Purpose: peer serializer and reference clock on the receive pins
// Assumes: one serial bit per system clock
// Notes:   bad_i spoils the start clock bit of each frame
`default_nettype none
module link_peer (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [9:0] word_i,
   input  wire logic       bad_i,
   output logic            ser_p_o,
   output logic            ser_n_o,
   output logic            ref_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int pos_q;
   // ===========================================
   // frame sender, reference toggles inside each frame
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pos_q <= 0;
         ser_p_o <= 1'b0;
         ref_o <= 1'b0;
      end else begin
         pos_q <= (pos_q == 11) ? 0 : pos_q + 1;
         ser_p_o <= (pos_q == 0) ? ~bad_i : (pos_q == 11) ? 1'b0 : word_i[pos_q-1];
         ref_o <= pos_q[1]; // keeps the reference live
      end
   end
   assign ser_n_o = ~ser_p_o;
endmodule : link_peer
`default_nettype wire

// [sim/serdes_pin_control_logic_bench.sv]
// Purpose: self-checking bench for the serdes pin control
// Assumes: registers over Avalon-MM, peer model on the link
// Notes:   expectations come from inline rules, not the design
`default_nettype none
module serdes_pin_control_logic_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, wclk = 1'b0, bad = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdo, rdat;
   logic [9:0]  tw = 10'h000, pw = 10'h000, ow;
   logic [2:0]  tdrv = 3'h0, tlvl = 3'h0;
   logic        wq, sp, sn, soe, pe, rc, rce, lk, lke, ip, in, rf;
   logic        ce = 1'b1, prev;
   logic [11:0] fr = 12'h000;
   logic [9:0]  old;
   int          n_errors = 0, n_compared = 0, k, j;
   always #5 sys_clk = ~sys_clk;
   link_peer peer (.clk_i(sys_clk), .resetn_i(resetn), .word_i(pw), .bad_i(bad),
      .ser_p_o(ip), .ser_n_o(in), .ref_o(rf));
   serdes_pin_ctl dut (.sys_clk_i(sys_clk), .resetn_i(resetn), .ce_i(ce),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF),
      .avs_writedata_i(wdat), .avs_readdata_o(rdo), .avs_waitrequest_o(wq),
      .tx_word_clk_i(wclk), .tx_word_i(tw), .ser_out_p_o(sp), .ser_out_n_o(sn),
      .ser_out_oe_n_o(soe), .ser_in_p_i(ip), .ser_in_n_i(in), .rx_reference_clk_i(rf),
      .par_word_out_o(ow), .par_word_out_oe_n_o(pe), .rec_clk_o(rc), .rec_clk_oe_n_o(rce),
      .lock_n_o(lk), .lock_oe_n_o(lke), .tap_drive_i(tdrv), .tap_level_i(tlvl));
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   // one bus cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wq !== 1'b0 && n < 50);
      if (n >= 50) n_errors++;
      rdat = rdo;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic reg_is(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check("register", e, rdat);
   endtask : reg_is
   task automatic go(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : go
   task automatic print_verdict;
      if (n_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #600us;
      n_errors++;
      print_verdict();
   end
   // ===========================================
   // main sequence
   initial begin
      k = $urandom(32'hcbef);
      go(12);
      resetn <= 1'b1;
      // one low-to-high step per frame, so only the start bit can frame it
      pw <= 10'h3FF >> ($urandom % 10);
      reg_is(4'h0, 32'h0);
      reg_is(4'h2, 32'h0);
      bus(1'b1, 4'h4, 32'hFF);
      reg_is(4'h4, 32'h1D);
      tdrv <= 3'h7;
      tlvl <= 3'h2;
      reg_is(4'h4, 32'h09);
      for (int e = 0; e < 2; e++) begin
         bus(1'b1, 4'h0, 32'h06 | e);
         tw <= 10'h155;
         wclk <= 1'b1;
         go(4);
         tw <= 10'h2AA;
         wclk <= 1'b0;
         go(4);
         reg_is(4'hC, e ? 32'h155 : 32'h2AA);
         check("ser_oe_n", 1'b0, soe);
      end
      // serial pin: one whole frame of the held word, pair complementary
      k = 0;
      repeat (23) begin
         go(1);
         fr = {fr[10:0], sp};
         if (fr === 12'hD54 && sn === ~sp) k++;
      end
      check("serial frame", 1, k);
      for (int t = 0; t < 2; t++) begin
         bus(1'b1, 4'h0, 32'h07 | (32'h08 << t));
         go(30);
         bus(1'b1, 4'h0, 32'h07);
         go(12200);
         bus(1'b0, 4'h4, 32'h0);
         check("train busy", 1'b1, rdat[1]);
         go(900);
         bus(1'b0, 4'h4, 32'h0);
         check("train idle", 1'b0, rdat[1]);
      end
      bus(1'b1, 4'h0, 32'h05);
      go(3);
      check("ser_oe_n off", 1'b1, soe);
      bus(1'b1, 4'h0, 32'h03);
      go(3);
      check("ser_oe_n sleep", 1'b1, soe);
      bus(1'b1, 4'h0, 32'hEE);
      k = 0;
      while (lk !== 1'b0 && k < 600) begin
         go(1);
         k++;
      end
      check("lock_n", 1'b0, lk);
      bus(1'b1, 4'h0, 32'hE0);
      go(40);
      check("word", pw, ow);
      check("word oe_n", 1'b0, pe);
      reg_is(4'h8, pw);
      k = 0;
      prev = rc;
      repeat (120) begin
         go(1);
         if (rc === 1'b1 && prev === 1'b0) k++;
         prev = rc;
      end
      check("rclk rises", 10, k);
      // enable low freezes all; 24 frozen edges keep the frame phase
      ce <= 1'b0;
      go(1);
      k = 0;
      prev = rc;
      repeat (23) begin
         go(1);
         if (rc !== prev) k++;
         prev = rc;
      end
      ce <= 1'b1;
      check("frozen rclk", 0, k);
      // new word must meet the recovered clock edge that the select names
      for (int r = 0; r < 2; r++) begin
         old = ow;
         bus(1'b1, 4'h0, 32'hC0 | (32'(r) << 5));
         pw <= pw[9] ? 10'h001 : {pw[8:0], 1'b1};
         j = 0;
         while (ow === old && j < 60) begin
            prev = rc;
            go(1);
            j++;
         end
         check("rx edge", r ? 3'b110 : 3'b101, {j < 60, prev, rc});
      end
      bus(1'b1, 4'h0, 32'hA0);
      go(3);
      check("oe off", 3'b110, {pe, rce, lke});
      bus(1'b1, 4'h0, 32'h60);
      go(3);
      check("asleep", 3'b111, {pe, rce, lke});
      bus(1'b1, 4'h0, 32'hE0);
      go(600);
      bad <= 1'b1;
      // all-zero data leaves no false start bit to relock on
      pw <= 10'h000;
      go(36);
      check("lock held", 1'b0, lk);
      go(60);
      check("lock lost", 3'b111, {lk, pe, rce});
      print_verdict();
   end
endmodule : serdes_pin_control_logic_bench
`default_nettype wire
